// ===== hdl/power_fault_retry_pkg.sv
// Package with command codes, field layouts, reset values and timing constants of the fault-retry sequencer
package power_fault_retry_pkg;
    // Command codes on the register port
    localparam logic [7:0] code_startup_timeout_fault_action = 8'h63;
    localparam logic [7:0] code_turn_off_delay = 8'h64;
    localparam logic [7:0] code_turn_off_fall_time = 8'h65;
    localparam logic [7:0] code_power_down_duration_limit = 8'h66;
    localparam logic [7:0] code_fault_time_unit = 8'hd2;
    localparam logic [7:0] code_sequencer_status = 8'hd3;

    // Fault action byte layout
    localparam int resp_hi = 7;
    localparam int resp_lo = 6;
    localparam int retry_hi = 5;
    localparam int retry_lo = 3;
    localparam int delay_hi = 2;
    localparam int delay_lo = 0;

    localparam logic [1:0] resp_ignore = 2'h0;
    localparam logic [1:0] resp_run_then_retry = 2'h1;
    localparam logic [1:0] resp_disable_retry = 2'h2;
    localparam logic [1:0] resp_disable_latch = 2'h3;

    localparam logic [2:0] retry_none = 3'h0;
    localparam logic [2:0] retry_forever = 3'h7;

    // Linear data format
    localparam int lin_exp_hi = 15;
    localparam int lin_exp_lo = 11;
    localparam int lin_mant_hi = 10;

    // Reset values
    localparam logic [7:0] reset_fault_action = 8'h00;
    localparam logic [15:0] reset_word = 16'h0000;
    localparam logic [15:0] reset_time_unit = 16'h0001;

    // Status word bit positions
    localparam int stat_warn = 0;
    localparam int stat_latched = 1;
    localparam int stat_enabled = 2;
    localparam int stat_falling = 3;

    // Timing
    localparam int clk_hz = 40_000_000;
    localparam int ms_per_s = 1000;
    localparam int time_unit_ms = 1;
    localparam int ms_cycles = (clk_hz / ms_per_s) * time_unit_ms;

    typedef enum logic [2:0]
    {
        st_off = 3'b000,
        st_on = 3'b001,
        st_fault_run = 3'b010,
        st_retry_wait = 3'b011,
        st_attempt = 3'b100,
        st_latched = 3'b101,
        st_off_delay = 3'b110,
        st_fall = 3'b111
    } seq_state_type;
endpackage : power_fault_retry_pkg

// ===== hdl/power_fault_retry_sequencer.sv
// Fault-retry and turn-off sequencer with its command-code register port
//
// Overview of operation
// - Codes 100/101/110 give four/five/six restarts
// - Retries exhausted: output off until fault cleared
// - Attempt spacing, start to start, is delay
// - Code 111 retries without limit
// - Continuous retry ends on off, bias, fault
// - Delay field selects two to its power
// - Delay is run time or retry spacing
// - Base unit comes from register 0xD2
// - Startup timeout uses output-voltage fault unit
// - Wait turn-off delay before output falls
// - Output ramps down over programmed fall time
// - Power-down duration limit overrun raises a sticky warning
// - Code 000 means no restart, stay off
// - Response 01 runs delay, then retries
`timescale 1ns/1ps
module power_fault_retry_sequencer #(
    parameter int ms_cycles = power_fault_retry_pkg::ms_cycles
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_code,
    input wire logic [15:0] reg_wdata,
    input wire logic on_command,
    input wire logic bias_ok,
    input wire logic startup_fault,
    input wire logic hard_fault,
    input wire logic output_good,
    input wire logic output_low,
    input wire logic clear_faults,
    output logic [15:0] reg_rdata_q,
    output logic output_enable_q,
    output logic fall_active_q,
    output logic fault_latched_q,
    output logic power_down_warn_q
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] linear_to_ms(input logic [15:0] v);
        logic signed [4:0] e;
        logic [31:0] m;
        e = v[power_fault_retry_pkg::lin_exp_hi:power_fault_retry_pkg::lin_exp_lo];
        // Negative mantissas make no sense as times and read as zero
        m = v[power_fault_retry_pkg::lin_mant_hi] ? 32'h0000_0000
            : {21'h00_0000, v[power_fault_retry_pkg::lin_mant_hi:0]};
        if (e < 0)
            linear_to_ms = m >> (-e);
        else
            linear_to_ms = m << e;
    endfunction : linear_to_ms

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] action_q, action_d;
    logic [15:0] off_delay_q, off_delay_d, fall_q, fall_d, limit_q, limit_d, unit_q, unit_d;
    logic [15:0] rdata_d;
    logic warn_d;

    always_comb
    begin
        action_d = action_q;
        off_delay_d = off_delay_q;
        fall_d = fall_q;
        limit_d = limit_q;
        unit_d = unit_q;
        rdata_d = reg_rdata_q;
        if (reg_write)
        begin
            unique case (reg_code)
                power_fault_retry_pkg::code_startup_timeout_fault_action: action_d = reg_wdata[7:0];
                power_fault_retry_pkg::code_turn_off_delay: off_delay_d = reg_wdata;
                power_fault_retry_pkg::code_turn_off_fall_time: fall_d = reg_wdata;
                power_fault_retry_pkg::code_power_down_duration_limit: limit_d = reg_wdata;
                power_fault_retry_pkg::code_fault_time_unit: unit_d = reg_wdata;
                default: ;
            endcase
        end
        if (reg_read)
        begin
            unique case (reg_code)
                power_fault_retry_pkg::code_startup_timeout_fault_action: rdata_d = {8'h00, action_q};
                power_fault_retry_pkg::code_turn_off_delay: rdata_d = off_delay_q;
                power_fault_retry_pkg::code_turn_off_fall_time: rdata_d = fall_q;
                power_fault_retry_pkg::code_power_down_duration_limit: rdata_d = limit_q;
                power_fault_retry_pkg::code_fault_time_unit: rdata_d = unit_q;
                power_fault_retry_pkg::code_sequencer_status:
                begin
                    rdata_d = 16'h0000;
                    rdata_d[power_fault_retry_pkg::stat_warn] = power_down_warn_q;
                    rdata_d[power_fault_retry_pkg::stat_latched] = fault_latched_q;
                    rdata_d[power_fault_retry_pkg::stat_enabled] = output_enable_q;
                    rdata_d[power_fault_retry_pkg::stat_falling] = fall_active_q;
                end
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            action_q <= power_fault_retry_pkg::reset_fault_action;
            off_delay_q <= power_fault_retry_pkg::reset_word;
            fall_q <= power_fault_retry_pkg::reset_word;
            limit_q <= power_fault_retry_pkg::reset_word;
            unit_q <= power_fault_retry_pkg::reset_time_unit;
            reg_rdata_q <= power_fault_retry_pkg::reset_word;
        end
        else
        begin
            action_q <= action_d;
            off_delay_q <= off_delay_d;
            fall_q <= fall_d;
            limit_q <= limit_d;
            unit_q <= unit_d;
            reg_rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick shared by every timer
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic ms_tick;
    assign ms_tick = (tick_cnt_q == 32'(ms_cycles - 1));
    always_comb
        tick_cnt_d = ms_tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;

    ////////////////////////////////////////////////////////////////////////////
    power_fault_retry_pkg::seq_state_type state_q, state_d;
    logic [31:0] timer_q, timer_d, pd_cnt_q, pd_cnt_d;
    logic [2:0] attempts_q, attempts_d;
    logic on_prev_q, pd_run_q, pd_run_d;
    logic enable_d, fall_d2, latched_d;
    logic [1:0] resp;
    logic [2:0] retries;
    logic [31:0] delay_ms, off_delay_ms, fall_ms, limit_ms;
    logic timer_done, on_cycle;

    assign resp = action_q[power_fault_retry_pkg::resp_hi:power_fault_retry_pkg::resp_lo];
    assign retries = action_q[power_fault_retry_pkg::retry_hi:power_fault_retry_pkg::retry_lo];
    // Multiplier 2**n times base unit; the 16-bit unit shifted by at most 7 always fits in 32 bits
    assign delay_ms = {16'h0000, unit_q} << action_q[power_fault_retry_pkg::delay_hi:power_fault_retry_pkg::delay_lo];
    assign off_delay_ms = linear_to_ms(off_delay_q);
    assign fall_ms = linear_to_ms(fall_q);
    assign limit_ms = linear_to_ms(limit_q);
    assign timer_done = (timer_q == 32'h0000_0000);
    assign on_cycle = on_command && !on_prev_q;

    always_comb
    begin
        state_d = state_q;
        timer_d = (ms_tick && !timer_done) ? timer_q - 32'h0000_0001 : timer_q;
        attempts_d = attempts_q;
        enable_d = output_enable_q;
        fall_d2 = 1'b0;
        latched_d = fault_latched_q;
        pd_run_d = pd_run_q;
        pd_cnt_d = pd_cnt_q;
        warn_d = power_down_warn_q && !clear_faults;

        // Power-down watchdog runs from the off command until the output is low, the limit is hit or bias is lost
        if (pd_run_q)
        begin
            if (output_low)
                pd_run_d = 1'b0;
            else if (ms_tick)
                pd_cnt_d = pd_cnt_q + 32'h0000_0001;
            if (limit_ms != 32'h0000_0000 && pd_cnt_q >= limit_ms)
            begin
                warn_d = 1'b1;
                pd_run_d = 1'b0;
            end
        end

        unique case (state_q)
            power_fault_retry_pkg::st_off:
            begin
                enable_d = 1'b0;
                if (on_command && !latched_d)
                begin
                    enable_d = 1'b1;
                    state_d = power_fault_retry_pkg::st_on;
                end
            end
            power_fault_retry_pkg::st_on:
            begin
                if (startup_fault)
                begin
                    timer_d = delay_ms;
                    unique case (resp)
                        power_fault_retry_pkg::resp_ignore: ;
                        power_fault_retry_pkg::resp_run_then_retry:
                            state_d = power_fault_retry_pkg::st_fault_run;
                        power_fault_retry_pkg::resp_disable_retry:
                        begin
                            enable_d = 1'b0;
                            state_d = power_fault_retry_pkg::st_retry_wait;
                        end
                        power_fault_retry_pkg::resp_disable_latch:
                        begin
                            enable_d = 1'b0;
                            latched_d = 1'b1;
                            state_d = power_fault_retry_pkg::st_latched;
                        end
                    endcase
                end
            end
            power_fault_retry_pkg::st_fault_run:
            begin
                if (!startup_fault)
                    state_d = power_fault_retry_pkg::st_on;
                else if (timer_done)
                begin
                    enable_d = 1'b0;
                    timer_d = delay_ms;
                    state_d = power_fault_retry_pkg::st_retry_wait;
                end
            end
            power_fault_retry_pkg::st_retry_wait:
            begin
                if (retries == power_fault_retry_pkg::retry_none
                    || (retries != power_fault_retry_pkg::retry_forever && attempts_q >= retries))
                begin
                    latched_d = 1'b1;
                    state_d = power_fault_retry_pkg::st_latched;
                end
                else if (timer_done)
                begin
                    enable_d = 1'b1;
                    timer_d = delay_ms;
                    if (retries != power_fault_retry_pkg::retry_forever)
                        attempts_d = attempts_q + 3'h1;
                    state_d = power_fault_retry_pkg::st_attempt;
                end
            end
            power_fault_retry_pkg::st_attempt:
            begin
                if (startup_fault)
                begin
                    enable_d = 1'b0;
                    state_d = power_fault_retry_pkg::st_retry_wait;
                end
                else if (output_good)
                begin
                    attempts_d = 3'h0;
                    state_d = power_fault_retry_pkg::st_on;
                end
            end
            power_fault_retry_pkg::st_latched:
            begin
                enable_d = 1'b0;
                attempts_d = 3'h0;
                if (clear_faults || on_cycle)
                begin
                    latched_d = 1'b0;
                    state_d = power_fault_retry_pkg::st_off;
                end
            end
            power_fault_retry_pkg::st_off_delay:
            begin
                if (timer_done)
                begin
                    enable_d = 1'b0;
                    timer_d = fall_ms;
                    // Ramp flag rises with the enable drop so the fall starts without a gap
                    fall_d2 = (fall_ms != 32'h0000_0000);
                    state_d = power_fault_retry_pkg::st_fall;
                end
            end
            power_fault_retry_pkg::st_fall:
            begin
                fall_d2 = !timer_done;
                if (timer_done)
                    state_d = power_fault_retry_pkg::st_off;
            end
        endcase

        // Commanded off wins over any retry, running or not
        if (!on_command && state_q != power_fault_retry_pkg::st_off && state_q != power_fault_retry_pkg::st_off_delay
            && state_q != power_fault_retry_pkg::st_fall && state_q != power_fault_retry_pkg::st_latched)
        begin
            attempts_d = 3'h0;
            if (output_enable_q)
            begin
                timer_d = off_delay_ms;
                pd_run_d = 1'b1;
                pd_cnt_d = 32'h0000_0000;
                state_d = power_fault_retry_pkg::st_off_delay;
            end
            else
                state_d = power_fault_retry_pkg::st_off;
        end
        if (hard_fault && state_q != power_fault_retry_pkg::st_off)
        begin
            enable_d = 1'b0;
            fall_d2 = 1'b0;
            latched_d = 1'b1;
            state_d = power_fault_retry_pkg::st_latched;
        end
        if (!bias_ok)
        begin
            enable_d = 1'b0;
            fall_d2 = 1'b0;
            latched_d = 1'b0;
            attempts_d = 3'h0;
            pd_run_d = 1'b0;
            state_d = power_fault_retry_pkg::st_off;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tick_cnt_q <= 32'h0000_0000;
            state_q <= power_fault_retry_pkg::st_off;
            timer_q <= 32'h0000_0000;
            pd_cnt_q <= 32'h0000_0000;
            attempts_q <= 3'h0;
            on_prev_q <= 1'b0;
            pd_run_q <= 1'b0;
            output_enable_q <= 1'b0;
            fall_active_q <= 1'b0;
            fault_latched_q <= 1'b0;
            power_down_warn_q <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            state_q <= state_d;
            timer_q <= timer_d;
            pd_cnt_q <= pd_cnt_d;
            attempts_q <= attempts_d;
            on_prev_q <= on_command;
            pd_run_q <= pd_run_d;
            output_enable_q <= enable_d;
            fall_active_q <= fall_d2;
            fault_latched_q <= latched_d;
            power_down_warn_q <= warn_d;
        end
    end
endmodule : power_fault_retry_sequencer

// ===== verification/power_stage_model.sv
// Behavioural output stage that answers the sequencer's enable and fall
`timescale 1ns/1ps
module power_stage_model
(
    input wire logic clk_sys,
    input wire logic enable,
    input wire logic falling,
    input wire logic slow,
    output logic output_good,
    output logic output_low
);
    int up_cnt = 0;
    int down_cnt = 0;
    always @(posedge clk_sys)
    begin
        up_cnt <= enable ? up_cnt + 1 : 0;
        down_cnt <= (enable || falling) ? 0 : down_cnt + 1;
    end
    // A slow discharge lets the power-down limit run out on purpose
    assign output_good = enable && up_cnt >= 3;
    assign output_low = !enable && !falling && down_cnt >= (slow ? 60 : 1);
endmodule : power_stage_model

// ===== verification/power_fault_retry_sva.sv
// Port checker of the fault-retry sequencer
`timescale 1ns/1ps
module power_fault_retry_sva #(
    parameter int ms_cycles = 4
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_code,
    input wire logic [15:0] reg_wdata,
    input wire logic on_command,
    input wire logic bias_ok,
    input wire logic startup_fault,
    input wire logic hard_fault,
    input wire logic output_good,
    input wire logic output_low,
    input wire logic clear_faults,
    input wire logic [15:0] reg_rdata_q,
    input wire logic output_enable_q,
    input wire logic fall_active_q,
    input wire logic fault_latched_q,
    input wire logic power_down_warn_q
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    logic [7:0] act_q;
    logic [15:0] toff_q;
    logic [15:0] fall_q;
    logic [15:0] lim_q;
    // Shadow copies of the settings, updated like the design's registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            act_q <= 8'h00;
            toff_q <= 16'h0000;
            fall_q <= 16'h0000;
            lim_q <= 16'h0000;
        end
        else if (reg_write)
        begin
            if (reg_code == 8'h63)
                act_q <= reg_wdata[7:0];
            if (reg_code == 8'h64)
                toff_q <= reg_wdata;
            if (reg_code == 8'h65)
                fall_q <= reg_wdata;
            if (reg_code == 8'h66)
                lim_q <= reg_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_read_action;
        reg_read && reg_code == 8'h63 |=> reg_rdata_q == {8'h00, $past(act_q)};
    endproperty
    a_read_action: assert property (p_read_action)
        else $error("action readback wrong");
    property p_latch_off;
        fault_latched_q |-> !output_enable_q;
    endproperty
    a_latch_off: assert property (p_latch_off)
        else $error("output on while latched");
    property p_forever;
        $rose(fault_latched_q) && act_q[7:6] == 2'h2 && act_q[5:3] == 3'h7 |-> $past(hard_fault);
    endproperty
    a_forever: assert property (p_forever)
        else $error("continuous retry gave up");
    property p_bias;
        !bias_ok |=> !output_enable_q && !fault_latched_q;
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias loss ignored");
    property p_off_delay;
        $fell(on_command) && output_enable_q && toff_q != 16'h0000 && bias_ok && !hard_fault && !startup_fault
            |=> output_enable_q [*2];
    endproperty
    a_off_delay: assert property (p_off_delay)
        else $error("turn-off delay skipped");
    property p_fall_off;
        $fell(output_enable_q) && !on_command && !fault_latched_q && fall_q != 16'h0000 && bias_ok
            |-> fall_active_q && !output_enable_q;
    endproperty
    a_fall_off: assert property (p_fall_off)
        else $error("fall ramp missing");
    property p_warn_limit;
        $rose(power_down_warn_q) |-> lim_q != 16'h0000 && !$past(output_low);
    endproperty
    a_warn_limit: assert property (p_warn_limit)
        else $error("warning without limit");
    property p_warn_sticky;
        power_down_warn_q && !clear_faults && bias_ok |=> power_down_warn_q;
    endproperty
    a_warn_sticky: assert property (p_warn_sticky)
        else $error("warning lost");
endmodule : power_fault_retry_sva
bind power_fault_retry_sequencer power_fault_retry_sva #(.ms_cycles(ms_cycles)) power_fault_retry_sva_i (.clk_sys,
    .reset, .reg_write, .reg_read, .reg_code, .reg_wdata, .on_command, .bias_ok, .startup_fault, .hard_fault,
    .output_good, .output_low, .clear_faults, .reg_rdata_q, .output_enable_q, .fall_active_q, .fault_latched_q,
    .power_down_warn_q);

// ===== verification/test_power_fault_retry_sequencer.sv
// Self-checking bench of the fault-retry and turn-off sequencer
`timescale 1ns/1ps
module test_power_fault_retry_sequencer;
    localparam int ms = 4;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_code = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic on_command = 1'b0;
    logic bias_ok = 1'b1;
    logic startup_fault = 1'b0;
    logic hard_fault = 1'b0;
    logic clear_faults = 1'b0;
    logic slow = 1'b0;
    logic output_good, output_low, output_enable_q, fall_active_q, fault_latched_q, power_down_warn_q;
    logic [15:0] reg_rdata_q;
    logic [31:0] seed = 32'h50;
    int err_total = 0;
    int comparisons = 0;
    power_fault_retry_sequencer #(.ms_cycles(ms)) power_fault_retry_sequencer_i (.clk_sys, .reset, .reg_write,
        .reg_read, .reg_code, .reg_wdata, .on_command, .bias_ok, .startup_fault, .hard_fault, .output_good,
        .output_low, .clear_faults, .reg_rdata_q, .output_enable_q, .fall_active_q, .fault_latched_q,
        .power_down_warn_q);
    power_stage_model power_stage_model_i (.clk_sys, .enable(output_enable_q), .falling(fall_active_q), .slow,
        .output_good, .output_low);
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    // Restart spacing in cycles: unit of 1 or 2 ms times two to the delay code
    function automatic int retry_span(input int r);
        return ms * (1 + r % 2) * (1 << (r % 4));
    endfunction : retry_span
    task automatic wrap_up();
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // Inputs always change 2 ns after the edge so the design sees them settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : cyc
    task automatic reg_wr(input logic [7:0] code, input logic [15:0] data);
        reg_code = code;
        reg_wdata = data;
        reg_write = 1'b1;
        cyc(1);
        reg_write = 1'b0;
        // Idle edge so a following call never toggles the strobe within one time step
        cyc(1);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] code, input logic [15:0] exp, input string what);
        reg_code = code;
        reg_read = 1'b1;
        cyc(1);
        reg_read = 1'b0;
        check(reg_rdata_q, exp, what);
        cyc(1);
    endtask : reg_rd
    task automatic wait_en(input logic lvl, output int n);
        n = 0;
        while (output_enable_q !== lvl && n < 1000)
        begin
            cyc(1);
            n++;
        end
    endtask : wait_en
    task automatic count_rises(input int span, input int per, output int rises);
        int last;
        logic prev;
        rises = 0;
        last = 0;
        for (int t = 0; t < span; t++)
        begin
            prev = output_enable_q;
            cyc(1);
            if (!prev && output_enable_q)
            begin
                if (rises > 0)
                    check(t - last >= per - ms && t - last <= per + ms, 1'b1, "spacing");
                rises++;
                last = t;
            end
        end
    endtask : count_rises
    task automatic settle();
        startup_fault = 1'b0;
        hard_fault = 1'b0;
        bias_ok = 1'b1;
        on_command = 1'b0;
        cyc(2);
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        cyc(2);
        check(output_enable_q | fault_latched_q, 1'b0, "not cleared");
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
    initial
    begin
        int n;
        int rises;
        int per;
        logic [15:0] v;
        cyc(4);
        reset = 1'b0;
        reg_rd(8'h63, 16'h0000, "action reset");
        reg_rd(8'h64, 16'h0000, "delay reset");
        reg_rd(8'h65, 16'h0000, "fall reset");
        reg_rd(8'h66, 16'h0000, "limit reset");
        reg_rd(8'hd2, 16'h0001, "unit reset");
        reg_rd(8'h10, 16'h0000, "unmapped");
        for (int c = 8'h64; c <= 8'h66; c++)
        begin
            v = rnd();
            reg_wr(c[7:0], v);
            reg_rd(c[7:0], v, "readback");
        end
        reg_wr(8'h63, 16'h55aa);
        reg_rd(8'h63, 16'h00aa, "action byte");
        reg_wr(8'h64, 16'h0000);
        reg_wr(8'h65, 16'h0000);
        for (int r = 0; r < 8; r++)
        begin
            per = retry_span(r);
            reg_wr(8'hd2, 16'(1 + r % 2));
            reg_wr(8'h63, {8'h00, 2'h2, 3'(r), 3'(r % 4)});
            on_command = 1'b1;
            wait_en(1'b1, n);
            startup_fault = 1'b1;
            count_rises(per * 9 + 20, per, rises);
            check(r == 7 ? rises >= 7 : rises == r, 1'b1, "attempts");
            check(fault_latched_q, r < 7, "latch after retries");
            if (r == 7)
            begin
                hard_fault = 1'b1;
                cyc(2);
                check(fault_latched_q, 1'b1, "other fault");
                bias_ok = 1'b0;
                cyc(2);
                check(fault_latched_q, 1'b0, "bias loss");
            end
            settle();
        end
        reg_wr(8'hd2, 16'h0001);
        reg_wr(8'h63, 16'h0042);
        on_command = 1'b1;
        wait_en(1'b1, n);
        startup_fault = 1'b1;
        cyc(8);
        check(output_enable_q, 1'b1, "runs on");
        cyc(20);
        check(output_enable_q, 1'b0, "stops after delay");
        check(fault_latched_q, 1'b1, "no retry");
        settle();
        reg_wr(8'h63, 16'h0088);
        on_command = 1'b1;
        wait_en(1'b1, n);
        startup_fault = 1'b1;
        cyc(2);
        startup_fault = 1'b0;
        wait_en(1'b1, n);
        check(n <= 3 * ms, 1'b1, "attempt time");
        cyc(8);
        check(output_enable_q, 1'b1, "restart held");
        startup_fault = 1'b1;
        count_rises(40, 2 * ms, rises);
        check(rises == 1, 1'b1, "full allowance");
        settle();
        reg_wr(8'h63, 16'h0000);
        reg_wr(8'h64, 16'h0003);
        reg_wr(8'h65, 16'h0002);
        reg_wr(8'h66, 16'h0008);
        for (int s = 0; s < 2; s++)
        begin
            slow = s[0];
            on_command = 1'b1;
            wait_en(1'b1, n);
            cyc(4);
            on_command = 1'b0;
            wait_en(1'b0, n);
            check(n >= 2 * ms && n <= 3 * ms + 2, 1'b1, "off delay");
            for (n = 0; fall_active_q === 1'b1 && n < 100; n++)
                cyc(1);
            check(n >= ms && n <= 2 * ms + 2, 1'b1, "fall time");
            cyc(80);
            check(power_down_warn_q, s[0], "limit");
            reg_rd(8'hd3, 16'(s) << power_fault_retry_pkg::stat_warn, "status");
            settle();
            check(power_down_warn_q, 1'b0, "warn clear");
        end
        wrap_up();
    end
endmodule : test_power_fault_retry_sequencer
